// ### logic/nv_mem_host_pkg.sv
// Constants for the host-side controller of an asynchronous byte-wide memory.
// Assumes a single 100 MHz system clock; all times but DRIVE_TO_DATA_PS and ADDR_TO_WEND_PS are converted to cycles here.
`default_nettype none

package nv_mem_host_pkg;

  // ----------------------------------------------------------------
  // Clock and pin widths
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 10000;
  localparam int ADDR_W        = 17;
  localparam int DATA_W        = 8;

  // ----------------------------------------------------------------
  // Times as printed, in picoseconds
  // ----------------------------------------------------------------
  localparam longint STARTUP_PS           = 64'd2000000000;  // 2 ms
  localparam int     CYCLE_MIN_PS         = 35000;
  localparam int     ADDRESS_TO_DATA_PS   = 35000;  // address_to_data_delay
  localparam int     DRIVE_TO_DATA_PS     = 15000;  // drive_to_data_delay
  localparam int     DRIVE_RELEASE_PS     = 10000;
  localparam int     STROBE_LOW_WIDTH_PS  = 15000;  // strobe_low_width
  localparam int     ADDR_TO_WEND_PS      = 18000;  // output drive high
  localparam int     DATA_TO_WEND_PS      = 10000;
  localparam int     WRITE_RECOVERY_PS    = 12000;
  localparam int     HIGH_STEADY_PS       = 2000;

  // ----------------------------------------------------------------
  // Cycle counts: least times round up
  // ----------------------------------------------------------------
  localparam int STARTUP_CYC      = int'((STARTUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int READ_ACCESS_CYC  = (ADDRESS_TO_DATA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RELEASE_CYC      = (DRIVE_RELEASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STROBE_LOW_CYC   = (STROBE_LOW_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DATA_SETUP_CYC   = (DATA_TO_WEND_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RECOVERY_CYC     = (WRITE_RECOVERY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HIGH_STEADY_CYC  = (HIGH_STEADY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYCLE_MIN_CYC    = (CYCLE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam int TIMER_W = 8;

endpackage : nv_mem_host_pkg

`default_nettype wire

// ### logic/nv_mem_host.sv
// Host controller driving an asynchronous byte-wide non-volatile memory.
// Assumes the memory pins attach directly; data pins are split in/out/enable.
//
// Summary of operation
// - After supply good, wait 2 ms before any access.
// - Hold select and strobe high during power-up, longer than startup.
// - A supply drop restarts the full startup wait.
// - Keep the write strobe high throughout a read.
// - Read data valid 35 ns after select falls with address set up.
// - Address valid 18 ns before write end, 20 ns with drive low.
// - Write strobe low at least 15 ns each write.
// - Write data valid at least 10 ns before strobe rises.
// - Writes happen only while select and strobe are both low.
// - Raised strobe or select stays high at least 2 ns.
`default_nettype none

module nv_mem_host #(
  parameter int STARTUP_CYCLES = nv_mem_host_pkg::STARTUP_CYC
) (
  input  wire logic                                i_clk,
  input  wire logic                                i_sys_rst,
  input  wire logic                                i_supply_ok,
  input  wire logic                                i_req,
  input  wire logic                                i_we,
  input  wire logic [nv_mem_host_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [nv_mem_host_pkg::DATA_W-1:0] i_wdata,
  output logic                                     o_ready,
  output logic                                     o_rvalid,
  output logic      [nv_mem_host_pkg::DATA_W-1:0] o_rdata,
  output logic      [nv_mem_host_pkg::ADDR_W-1:0] o_mem_addr,
  output logic                                     o_mem_select_n,
  output logic                                     o_mem_strobe_n,
  output logic                                     o_mem_drive_n,
  input  wire logic [nv_mem_host_pkg::DATA_W-1:0] i_mem_dq,
  output logic      [nv_mem_host_pkg::DATA_W-1:0] o_mem_dq,
  output logic                                     o_mem_dq_oe
);

  // ----------------------------------------------------------------
  // Supply-good synchroniser (pin, three flops)
  // ----------------------------------------------------------------
  logic [2:0] sup_sync_reg;
  logic [2:0] sup_sync_next;
  logic       sup_ok_reg;
  logic       sup_ok_next;

  // Level accepted only once the second and third flops agree
  always_comb
  begin
    sup_sync_next = {sup_sync_reg[1:0], i_supply_ok};
    sup_ok_next   = sup_ok_reg;
    if (sup_sync_reg[1] == sup_sync_reg[2])
    begin
      sup_ok_next = sup_sync_reg[2];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      sup_sync_reg <= 3'h0;
      sup_ok_reg   <= 1'b0;
    end
    else
    begin
      sup_sync_reg <= sup_sync_next;
      sup_ok_reg   <= sup_ok_next;
    end
  end

  // ----------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_STARTUP, ST_IDLE, ST_RD_ACCESS, ST_RD_RELEASE,
    ST_WR_SETUP, ST_WR_STROBE, ST_WR_RECOVER, ST_GAP
  } state_t;

  localparam int SU_W = $clog2(STARTUP_CYCLES + 1);

  state_t                                   state_reg,   state_next;
  logic [SU_W-1:0]                          startup_reg, startup_next;
  logic [nv_mem_host_pkg::TIMER_W-1:0]      timer_reg,   timer_next;
  logic [nv_mem_host_pkg::TIMER_W-1:0]      cyc_reg,     cyc_next;
  logic [nv_mem_host_pkg::ADDR_W-1:0]       addr_reg,    addr_next;
  logic [nv_mem_host_pkg::DATA_W-1:0]       wdata_reg,   wdata_next;
  logic [nv_mem_host_pkg::DATA_W-1:0]       rdata_reg,   rdata_next;
  logic                                     rvalid_reg,  rvalid_next;
  logic                                     sel_n_reg,   sel_n_next;
  logic                                     stb_n_reg,   stb_n_next;
  logic                                     drv_n_reg,   drv_n_next;
  logic                                     oe_reg,      oe_next;

  // Cycle count as a timer width, cut on purpose
  function automatic logic [nv_mem_host_pkg::TIMER_W-1:0] cyc(input int n);
    cyc = nv_mem_host_pkg::TIMER_W'(n);
  endfunction : cyc

  // Accept a request only once idle and the cycle spacing has elapsed
  assign o_ready = (state_reg == ST_IDLE) && (cyc_reg == '0);

  always_comb
  begin
    state_next   = state_reg;
    startup_next = startup_reg;
    timer_next   = (timer_reg != '0) ? timer_reg - cyc(1) : timer_reg;
    cyc_next     = (cyc_reg != '0) ? cyc_reg - cyc(1) : cyc_reg;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    rdata_next   = rdata_reg;
    rvalid_next  = 1'b0;
    sel_n_next   = sel_n_reg;
    stb_n_next   = stb_n_reg;
    drv_n_next   = drv_n_reg;
    oe_next      = oe_reg;
    if (!sup_ok_reg)
    begin
      // Supply low: abandon any access, restart the full wait
      state_next   = ST_STARTUP;
      startup_next = SU_W'(STARTUP_CYCLES);
      sel_n_next   = 1'b1;
      stb_n_next   = 1'b1;
      drv_n_next   = 1'b1;
      oe_next      = 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_STARTUP:
        begin
          if (startup_reg == '0)
          begin
            state_next = ST_IDLE;
          end
          else
          begin
            startup_next = startup_reg - SU_W'(1);
          end
        end
        ST_IDLE:
        begin
          if (i_req && o_ready)
          begin
            addr_next  = i_addr;
            wdata_next = i_wdata;
            cyc_next   = cyc(nv_mem_host_pkg::CYCLE_MIN_CYC);
            if (i_we)
            begin
              // Address first, strobe one cycle later; drive kept high
              state_next = ST_WR_SETUP;
              oe_next    = 1'b1;
            end
            else
            begin
              state_next = ST_RD_ACCESS;
              sel_n_next = 1'b0;
              drv_n_next = 1'b0;
              timer_next = cyc(nv_mem_host_pkg::READ_ACCESS_CYC);
            end
          end
        end
        ST_RD_ACCESS:
        begin
          // Strobe stays high for the whole read
          if (timer_reg == cyc(1))
          begin
            rdata_next  = i_mem_dq;
            rvalid_next = 1'b1;
            sel_n_next  = 1'b1;
            drv_n_next  = 1'b1;
            state_next  = ST_RD_RELEASE;
            timer_next  = cyc(nv_mem_host_pkg::RELEASE_CYC);
          end
        end
        ST_RD_RELEASE:
        begin
          // Memory may still drive the bus; hold off before next drive
          if (timer_reg == '0)
          begin
            state_next = ST_GAP;
            timer_next = cyc(nv_mem_host_pkg::HIGH_STEADY_CYC);
          end
        end
        ST_WR_SETUP:
        begin
          sel_n_next = 1'b0;
          stb_n_next = 1'b0;
          state_next = ST_WR_STROBE;
          // Strobe width covers data setup and address-to-end too
          timer_next = cyc(nv_mem_host_pkg::STROBE_LOW_CYC);
        end
        ST_WR_STROBE:
        begin
          if (timer_reg == cyc(1))
          begin
            stb_n_next = 1'b1;
            sel_n_next = 1'b1;
            state_next = ST_WR_RECOVER;
            timer_next = cyc(nv_mem_host_pkg::RECOVERY_CYC);
          end
        end
        ST_WR_RECOVER:
        begin
          // Address and data held past strobe rise
          if (timer_reg == '0)
          begin
            oe_next    = 1'b0;
            state_next = ST_GAP;
            timer_next = cyc(nv_mem_host_pkg::HIGH_STEADY_CYC);
          end
        end
        ST_GAP:
        begin
          if (timer_reg == '0)
          begin
            state_next = ST_IDLE;
          end
        end
        default:
        begin
          state_next = ST_STARTUP;
        end
      endcase
    end
  end

  // Reset holds select and strobe high and restarts the startup wait
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_reg   <= ST_STARTUP;
      startup_reg <= SU_W'(STARTUP_CYCLES);
      timer_reg   <= '0;
      cyc_reg     <= '0;
      addr_reg    <= '0;
      wdata_reg   <= '0;
      rdata_reg   <= '0;
      rvalid_reg  <= 1'b0;
      sel_n_reg   <= 1'b1;
      stb_n_reg   <= 1'b1;
      drv_n_reg   <= 1'b1;
      oe_reg      <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      startup_reg <= startup_next;
      timer_reg   <= timer_next;
      cyc_reg     <= cyc_next;
      addr_reg    <= addr_next;
      wdata_reg   <= wdata_next;
      rdata_reg   <= rdata_next;
      rvalid_reg  <= rvalid_next;
      sel_n_reg   <= sel_n_next;
      stb_n_reg   <= stb_n_next;
      drv_n_reg   <= drv_n_next;
      oe_reg      <= oe_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------
  assign o_rvalid       = rvalid_reg;
  assign o_rdata        = rdata_reg;
  assign o_mem_addr     = addr_reg;
  assign o_mem_select_n = sel_n_reg;
  assign o_mem_strobe_n = stb_n_reg;
  assign o_mem_drive_n  = drv_n_reg;    // High during writes, so memory floats
  assign o_mem_dq       = wdata_reg;
  assign o_mem_dq_oe    = oe_reg;

endmodule : nv_mem_host

`default_nettype wire

// ### verif/nv_mem_host_monitor.sv
// Checker for the memory host controller: timing of the memory pins.
// Assumes a 100 MHz clock; bound to nv_mem_host with its startup count.
`default_nettype none
module nv_mem_host_monitor #(parameter int STARTUP_CYCLES = 20) (
  input wire logic                                i_clk,
  input wire logic                                i_sys_rst,
  input wire logic                                i_supply_ok,
  input wire logic                                o_ready,
  input wire logic                                o_rvalid,
  input wire logic [nv_mem_host_pkg::ADDR_W-1:0] o_mem_addr,
  input wire logic                                o_mem_select_n,
  input wire logic                                o_mem_strobe_n,
  input wire logic                                o_mem_drive_n,
  input wire logic [nv_mem_host_pkg::DATA_W-1:0] o_mem_dq,
  input wire logic                                o_mem_dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Run of supply-good cycles, saturating
  // ----------------------------------------
  logic [31:0] up_cnt_reg;
  logic [31:0] up_cnt_next;
  always_comb
  begin
    up_cnt_next = (up_cnt_reg != 32'hffffffff) ? up_cnt_reg + 32'h1 : up_cnt_reg;
    if (!i_supply_ok) up_cnt_next = 32'h0;
  end
  always_ff @(posedge i_clk)
  begin
    up_cnt_reg <= i_sys_rst ? 32'h0 : up_cnt_next;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Pin relations; reset one must see reset itself, so it has no disable
  property p_reset;
    disable iff (1'b0) i_sys_rst |=> o_mem_select_n && o_mem_strobe_n && !o_mem_dq_oe && !o_ready;
  endproperty
  property p_startup; o_ready |-> up_cnt_reg > STARTUP_CYCLES; endproperty
  property p_brownout; !i_supply_ok [*6] |-> o_mem_select_n && o_mem_strobe_n && !o_ready; endproperty
  property p_read_strobe; !o_mem_drive_n |-> o_mem_strobe_n; endproperty
  property p_read_access;
    $rose(o_rvalid) |-> $past(o_mem_select_n, 4) == 1'b0 && $past(o_mem_drive_n, 4) == 1'b0;
  endproperty
  property p_strobe_width; $fell(o_mem_strobe_n) |-> !o_mem_strobe_n [*2]; endproperty
  property p_data_setup; $rose(o_mem_strobe_n) |-> $past(o_mem_dq_oe, 2) && o_mem_dq == $past(o_mem_dq, 2); endproperty
  property p_addr_setup; $rose(o_mem_strobe_n) |-> o_mem_addr == $past(o_mem_addr, 2); endproperty
  property p_addr_hold; $rose(o_mem_strobe_n) |=> $stable(o_mem_addr) [*2]; endproperty
  property p_overlap; !o_mem_strobe_n |-> !o_mem_select_n; endproperty
  property p_high_steady; $rose(o_mem_select_n) |=> o_mem_select_n; endproperty
  property p_spacing; $changed(o_mem_addr) |=> $stable(o_mem_addr) [*3]; endproperty
  a_reset: assert property (p_reset) else $error("pins active during reset");
  a_startup: assert property (p_startup) else $error("ready before startup wait");
  a_brownout: assert property (p_brownout) else $error("pins active with supply low");
  a_read_strobe: assert property (p_read_strobe) else $error("strobe low in read");
  a_read_access: assert property (p_read_access) else $error("read data taken too early");
  a_strobe_width: assert property (p_strobe_width) else $error("strobe pulse short");
  a_data_setup: assert property (p_data_setup) else $error("write data late");
  a_addr_setup: assert property (p_addr_setup) else $error("write address late");
  a_addr_hold: assert property (p_addr_hold) else $error("address hold short");
  a_overlap: assert property (p_overlap) else $error("strobe without select");
  a_high_steady: assert property (p_high_steady) else $error("select glitch");
  a_spacing: assert property (p_spacing) else $error("cycles too close");
  c_read: cover property ($rose(o_rvalid));
  c_write: cover property ($fell(o_mem_strobe_n));
  c_brownout: cover property ($fell(i_supply_ok));
endmodule : nv_mem_host_monitor
bind nv_mem_host nv_mem_host_monitor #(.STARTUP_CYCLES(STARTUP_CYCLES)) mon (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_supply_ok(i_supply_ok), .o_ready(o_ready), .o_rvalid(o_rvalid), .o_mem_addr(o_mem_addr),
  .o_mem_select_n(o_mem_select_n), .o_mem_strobe_n(o_mem_strobe_n), .o_mem_drive_n(o_mem_drive_n),
  .o_mem_dq(o_mem_dq), .o_mem_dq_oe(o_mem_dq_oe));
`default_nettype wire

// ### verif/nv_mem_model.sv
// Behavioural byte-wide memory seen from the host pins.
// Assumes a nanosecond time unit; invalid output shown as a changing pattern.
`default_nettype none
module nv_mem_model (
  input  wire logic [nv_mem_host_pkg::ADDR_W-1:0] i_addr,
  input  wire logic                                i_select_n,
  input  wire logic                                i_strobe_n,
  input  wire logic                                i_drive_n,
  input  wire logic                                i_supply_ok,
  input  wire logic [nv_mem_host_pkg::DATA_W-1:0] i_dq,
  input  wire logic                                i_dq_oe,
  output logic      [nv_mem_host_pkg::DATA_W-1:0] o_dq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:131071];
  realtime    t_addr = 0.0;
  realtime    t_sel = 0.0;
  realtime    t_drv = 0.0;
  realtime    t_wend = 0.0;
  logic       wr_on = 1'b0;
  initial o_dq = 8'h00;
  // Edge times that gate the access delays
  always @(i_addr) t_addr = $realtime;
  always @(negedge i_select_n) t_sel = $realtime;
  always @(negedge i_drive_n) t_drv = $realtime;
  always @(posedge i_strobe_n) t_wend = $realtime;
  // Store when the select/strobe overlap ends; low supply blocks it
  always @(i_select_n or i_strobe_n)
  begin
    if (wr_on && i_supply_ok && i_dq_oe) mem[i_addr] = i_dq;
    wr_on = !i_select_n && !i_strobe_n;
  end
  // Output polled each ns; no pull on the bus, so released means toggling
  always #1
  begin
    if (i_select_n || !i_strobe_n || i_drive_n) o_dq = ~o_dq;
    else if ($realtime - t_addr >= 35.0 && $realtime - t_sel >= 35.0 && $realtime - t_drv >= 15.0
             && $realtime - t_wend >= 3.0) o_dq = mem[i_addr];
    else if ($realtime - t_addr >= 3.0) o_dq = ~o_dq;
  end
endmodule : nv_mem_model
`default_nettype wire

// ### verif/test_nv_mem_host.sv
// Bench for the memory host controller against the behavioural memory.
// Assumes package, design, checker and model compile first.
`default_nettype none
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin fail_count++; \
  $display("MISMATCH at %0t: got %h, expected %h", $time, act, exp); end end
module test_nv_mem_host;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STARTUP = 20;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        supply_ok = 1'b1;
  logic        req = 1'b0;
  logic        we = 1'b0;
  logic [16:0] addr = 17'h00000;
  logic [7:0]  wdata = 8'h00;
  logic        ready, rvalid, sel_n, str_n, drv_n, dq_oe;
  logic [7:0]  rdata, dq_in, dq_out;
  logic [16:0] mem_addr;
  logic [16:0] tab_a [3] = '{17'h00000, 17'h1ffff, 17'h0aaaa};
  logic [7:0]  tab_d [3] = '{8'h5a, 8'ha5, 8'hff};
  int          fail_count = 0;
  int          checked = 0;
  int          cyc = 0;
  nv_mem_host #(.STARTUP_CYCLES(STARTUP)) uut (.i_clk(clk), .i_sys_rst(sys_rst), .i_supply_ok(supply_ok),
    .i_req(req), .i_we(we), .i_addr(addr), .i_wdata(wdata), .o_ready(ready), .o_rvalid(rvalid), .o_rdata(rdata),
    .o_mem_addr(mem_addr), .o_mem_select_n(sel_n), .o_mem_strobe_n(str_n), .o_mem_drive_n(drv_n),
    .i_mem_dq(dq_in), .o_mem_dq(dq_out), .o_mem_dq_oe(dq_oe));
  nv_mem_model far (.i_addr(mem_addr), .i_select_n(sel_n), .i_strobe_n(str_n), .i_drive_n(drv_n),
    .i_supply_ok(supply_ok), .i_dq(dq_out), .i_dq_oe(dq_oe), .o_dq(dq_in));
  always #5 clk = ~clk;
  // Hang guard: whole run is under two hundred cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000) begin fail_count++; end_sim(); end
  end
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  // Count falling edges until ready, bounded
  task automatic wait_ready(output int n);
    n = 0;
    while (ready !== 1'b1 && n < 200) begin @(negedge clk); n++; end
  endtask : wait_ready
  // One request held from a rising edge until the edge that takes it
  task automatic access(input logic w, input logic [16:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    req <= 1'b1; we <= w; addr <= a; wdata <= d;
    do begin @(negedge clk); n++; end while (ready !== 1'b1 && n < 200);
    @(posedge clk);
    req <= 1'b0;
  endtask : access
  task automatic rd(input logic [16:0] a, input logic [7:0] e);
    int n;
    access(1'b0, a, 8'h00);
    n = 0;
    while (rvalid !== 1'b1 && n < 8) begin @(negedge clk); n++; end
    // Select low for the access count, pulse on the edge where select rises, seen at the falling edge after
    `CHK(n, nv_mem_host_pkg::READ_ACCESS_CYC + 1)
    `CHK(rdata, e)
  endtask : rd
  task automatic t_startup;
    int n;
    wait_ready(n);
    // A bounded wait that ran out must not pass as a long startup
    `CHK(ready, 1'b1)
    `CHK(n >= STARTUP, 1'b1)
    `CHK(sel_n & str_n, 1'b1)
    $display("Test startup done");
  endtask : t_startup
  // Back-to-back writes at both address ends, then read back
  task automatic t_data;
    for (int i = 0; i < 3; i++) access(1'b1, tab_a[i], tab_d[i]);
    for (int i = 0; i < 3; i++) rd(tab_a[i], tab_d[i]);
    $display("Test write and read done");
  endtask : t_data
  // Supply lost as a write starts: strobe still pulses, model drops the store; full wait again, old byte kept
  task automatic t_brownout;
    int n;
    access(1'b1, 17'h00000, 8'h00);
    supply_ok <= 1'b0;
    repeat (8) @(negedge clk);
    `CHK(ready, 1'b0)
    `CHK(sel_n & str_n, 1'b1)
    @(posedge clk);
    supply_ok <= 1'b1;
    wait_ready(n);
    `CHK(ready, 1'b1)
    `CHK(n >= STARTUP, 1'b1)
    rd(17'h00000, 8'h5a);
    $display("Test brownout done");
  endtask : t_brownout
  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_startup();
    t_data();
    t_brownout();
    end_sim();
  end
endmodule : test_nv_mem_host
`default_nettype wire
